// ===== rtl/tlfm_top.sv
// tricolour led modulator: registers, flash sequencer, three duty modulators
// assumes the host link decodes bytes into single-cycle writes on this clock
// assumes req.addr holds steady while a read is under way
// led_on drives the external sink switches, sink_current_code their level
`timescale 1ns/1ps
module tlfm_top #(
  parameter int unsigned SUB_CYC = tlfm_pkg::SUB_CYC_DFLT,   // cycles per pulse slot
  parameter int unsigned TICK_CYC = tlfm_pkg::TICK_CYC_DFLT  // cycles per flash tick
) (
  input wire logic clock,                        // 20 MHz
  input wire logic nrst,                         // async reset, active low
  input wire tlfm_pkg::tlfm_req_s req,           // register write and address
  output logic [7:0] rdata,                      // read data for req.addr
  output tlfm_pkg::tlfm_rgb_s led_on,            // red/green/blue_output sink on
  output logic [1:0] sink_current_code           // shared sink current code
);
  import tlfm_pkg::*;

  logic [7:0] flash_timing_r;
  logic [7:0] red_intensity_current_r;
  logic [7:0] green_intensity_enable_phase_r;
  logic [7:0] blue_intensity_r;
  logic tricolor_enable;
  logic phase_select;
  logic [2:0] flash_on_time;
  logic [3:0] flash_period;
  logic [4:0] duty_code [3];
  logic [4:0] red_duty_code;
  logic [4:0] green_duty_code;
  logic [4:0] blue_duty_code;
  logic wr_flash;
  logic wr_red;
  logic wr_green;
  logic wr_blue;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  // one write strobe per register; other addresses are ignored
  assign wr_flash = req.wr && (req.addr == FLASH_TIMING_ADDR);
  assign wr_red = req.wr && (req.addr == RED_INTENSITY_CURRENT_ADDR);
  assign wr_green = req.wr && (req.addr == GREEN_INTENSITY_ENABLE_PHASE_ADDR);
  assign wr_blue = req.wr && (req.addr == BLUE_INTENSITY_ADDR);

  // reserved bits are kept and read back as written
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      flash_timing_r <= REG_RESET;
    end else if (wr_flash) begin
      flash_timing_r <= req.wdata;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      red_intensity_current_r <= REG_RESET;
    end else if (wr_red) begin
      red_intensity_current_r <= req.wdata;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      green_intensity_enable_phase_r <= REG_RESET;
    end else if (wr_green) begin
      green_intensity_enable_phase_r <= req.wdata;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      blue_intensity_r <= REG_RESET;
    end else if (wr_blue) begin
      blue_intensity_r <= req.wdata;
    end
  end

  // unmapped addresses read as zero
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata <= REG_RESET;
    end else begin
      case (req.addr)
        FLASH_TIMING_ADDR: rdata <= flash_timing_r;
        RED_INTENSITY_CURRENT_ADDR: rdata <= red_intensity_current_r;
        GREEN_INTENSITY_ENABLE_PHASE_ADDR: rdata <= green_intensity_enable_phase_r;
        BLUE_INTENSITY_ADDR: rdata <= blue_intensity_r;
        default: rdata <= REG_RESET;
      endcase
    end
  end

  assign tricolor_enable = green_intensity_enable_phase_r[ENABLE_BIT];
  assign phase_select = green_intensity_enable_phase_r[PHASE_BIT];
  assign flash_on_time = flash_timing_r[ON_MSB:ON_LSB];
  assign flash_period = flash_timing_r[PER_MSB:PER_LSB];
  assign red_duty_code = red_intensity_current_r[DUTY_MSB:DUTY_LSB];
  assign green_duty_code = green_intensity_enable_phase_r[DUTY_MSB:DUTY_LSB];
  assign blue_duty_code = blue_intensity_r[DUTY_MSB:DUTY_LSB];
  // channel index 0 red, 1 green, 2 blue
  assign duty_code[0] = red_duty_code;
  assign duty_code[1] = green_duty_code;
  assign duty_code[2] = blue_duty_code;

  // one cycle late, in step with the led outputs
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sink_current_code <= 2'h0;
    end else begin
      sink_current_code <= red_intensity_current_r[ISET_MSB:ISET_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flash sequencer
  logic [31:0] tick_cnt_r;
  tlfm_ticks_t flash_pos_r;
  tlfm_ticks_t period_ticks;
  logic tick;
  logic flash_gate;
  tlfm_ticks_t on_ticks;
  logic always_on;
  logic period_end;

  assign tick = (tick_cnt_r == TICK_CYC - 1);
  // period in ticks: base plus one step per code
  assign period_ticks = PER_BASE_TICKS + tlfm_ticks_t'(flash_period) * PER_STEP_TICKS;
  assign on_ticks = ON_TICKS[flash_on_time];
  assign always_on = (flash_period == PER_ALWAYS_ON);
  assign period_end = (flash_pos_r >= period_ticks - 8'h01);

  // time base held at zero while disabled, so enable starts a whole tick
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_r <= 32'h0;
    end else if (tick || !tricolor_enable) begin
      tick_cnt_r <= 32'h0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
    end
  end

  // a shorter period written mid-count wraps at the next tick
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      flash_pos_r <= '0;
    end else if (!tricolor_enable) begin
      flash_pos_r <= '0;
    end else if (tick) begin
      if (period_end) begin
        flash_pos_r <= '0;
      end else begin
        flash_pos_r <= flash_pos_r + 8'h01;
      end
    end
  end

  // on-time first, then off for the rest of the period
  assign flash_gate = always_on ||
                      (flash_pos_r < on_ticks);

  ////////////////////////////////////////////////////////////////////////////
  // pulse slot counter, eight slots per 160 Hz frame
  // free running from reset, shared by all three channels
  logic [SUB_W-1:0] sub_cnt_r;
  logic [SUB_W-1:0] sub_shift;
  logic slot_end;

  assign slot_end = (sub_cnt_r == SUB_W'(SUB_CYC - 1));

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sub_cnt_r <= '0;
    end else if (slot_end) begin
      sub_cnt_r <= '0;
    end else begin
      sub_cnt_r <= sub_cnt_r + 14'h0001;
    end
  end

  // delayed slot position for the shifted channel
  // SUB_CYC must exceed SHIFT_CYC; the delayed position wraps inside the slot
  assign sub_shift = (sub_cnt_r >= SUB_W'(SHIFT_CYC)) ?
                     sub_cnt_r - SUB_W'(SHIFT_CYC) :
                     sub_cnt_r + SUB_W'(SUB_CYC - SHIFT_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // channel modulators
  logic [2:0] chan_on_r;
  logic [2:0] shifted;
  logic red_output;
  logic green_output;
  logic blue_output;

  // red is never the delayed channel
  assign shifted[0] = 1'b0;
  assign shifted[1] = !phase_select;
  assign shifted[2] = phase_select;

  for (genvar c = 0; c < 3; c++) begin : g_chan
    logic [SUB_W-1:0] pos;
    logic [SUB_W-1:0] width;

    assign pos = shifted[c] ? sub_shift : sub_cnt_r;
    // a width beyond one slot keeps the channel on for the whole slot
    assign width = SUB_W'(duty_code[c] * STEP_CYC);
    // registered so the sink switches see no glitches
    always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
        chan_on_r[c] <= 1'b0;
      end else begin
        chan_on_r[c] <= tricolor_enable && flash_gate &&
                        ((duty_code[c] == DUTY_FULL) || (pos < width));
      end
    end
  end

  assign red_output = chan_on_r[0];
  assign green_output = chan_on_r[1];
  assign blue_output = chan_on_r[2];

  assign led_on.red = red_output;
  assign led_on.green = green_output;
  assign led_on.blue = blue_output;
endmodule // tlfm_top

// ===== rtl/tlfm_pkg.sv
// constants, types and register map of the tricolour flash modulator
// assumes a 20 MHz clock and a byte-wide register port from the host link
package tlfm_pkg;
  localparam int unsigned CLK_KHZ = 20000;
  // register offsets
  localparam logic [7:0] FLASH_TIMING_ADDR = 8'h50;
  localparam logic [7:0] RED_INTENSITY_CURRENT_ADDR = 8'h51;
  localparam logic [7:0] GREEN_INTENSITY_ENABLE_PHASE_ADDR = 8'h52;
  localparam logic [7:0] BLUE_INTENSITY_ADDR = 8'h53;
  localparam logic [7:0] REG_RESET = 8'h00;
  // field positions
  localparam int ENABLE_BIT = 7;
  localparam int PHASE_BIT = 6;
  localparam int DUTY_LSB = 0;
  localparam int DUTY_MSB = 4;
  localparam int ISET_LSB = 5;
  localparam int ISET_MSB = 6;
  localparam int PER_LSB = 0;
  localparam int PER_MSB = 3;
  localparam int ON_LSB = 4;
  localparam int ON_MSB = 6;
  // modulation timing
  localparam int unsigned FRAME_NS = 6250000;      // one 160 Hz frame
  localparam int unsigned PULSES = 8;              // pulses per frame
  localparam int unsigned SUB_CYC_DFLT = FRAME_NS / 1000 * CLK_KHZ / 1000 / PULSES;
  localparam int unsigned STEP_NS = 185185;        // 1 / 5.4 ms per code step
  localparam int unsigned STEP_CYC = STEP_NS * CLK_KHZ / 1000000 / PULSES;
  localparam int unsigned SHIFT_NS = 200000;
  localparam int unsigned SHIFT_CYC = SHIFT_NS * CLK_KHZ / 1000000;
  localparam logic [4:0] DUTY_FULL = 5'h1F;
  localparam int SUB_W = 14;
  // flash timing in 50 ms ticks
  localparam int unsigned TICK_MS = 50;
  localparam int unsigned TICK_CYC_DFLT = TICK_MS * CLK_KHZ;
  localparam logic [3:0] PER_ALWAYS_ON = 4'hF;
  localparam logic [7:0] PER_BASE_TICKS = 8'h14;   // 1.0 s
  localparam logic [7:0] PER_STEP_TICKS = 8'h0A;   // 0.5 s
  localparam int TICK_W = 8;
  typedef logic [TICK_W-1:0] tlfm_ticks_t;
  localparam tlfm_ticks_t ON_TICKS [8] = '{8'h02, 8'h03, 8'h04, 8'h05,
                                           8'h06, 8'h08, 8'h0A, 8'h0C};

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tlfm_req_s;

  typedef struct packed {
    logic red;
    logic green;
    logic blue;
  } tlfm_rgb_s;
endpackage

// ===== tb/tlfm_leds.sv
// led load model: counts cycles each sink draws current, and overlaps
// assumes led_on high means the sink is on
`timescale 1ns/1ps
module tlfm_leds (
  input wire logic clock, // clock
  input wire logic clr, // zero counts
  input wire tlfm_pkg::tlfm_rgb_s led_on, // sinks
  output logic [4:0][15:0] cnt // r g b rg rb
);
  import tlfm_pkg::*;
  logic [4:0] hit;
  assign hit = {led_on.red & led_on.blue, led_on.red & led_on.green,
                led_on.blue, led_on.green, led_on.red};
  always_ff @(posedge clock) begin
    for (int i = 0; i < 5; i++) cnt[i] <= clr ? 16'h0000 : cnt[i] + 16'(hit[i]);
  end
endmodule // tlfm_leds

// ===== tb/tlfm_sva.sv
// port checker for the led modulator
// assumes a bind into tlfm_top
`timescale 1ns/1ps
module tlfm_sva #(
  parameter int unsigned SUB_CYC = 5000
) (
  input wire logic clock, // clock
  input wire logic nrst, // reset
  input wire tlfm_pkg::tlfm_req_s req, // request
  input wire logic [7:0] rdata, // read data
  input wire tlfm_pkg::tlfm_rgb_s led_on, // sinks
  input wire logic [1:0] sink_current_code // current
);
  import tlfm_pkg::*;
  logic [7:0] sh_r [4];
  logic [15:0] qt_r, gp_r, rn_r;
  logic hit, on, okp;
  logic [7:0] rx;
  assign hit = req.addr[7:2] == 6'h14;
  assign rx = hit ? sh_r[req.addr[1:0]] : 8'h00;
  assign on = qt_r > 16'h0002 && sh_r[2][7] && sh_r[0][3:0] == 4'hF;
  assign okp = on && qt_r > 2 * SUB_CYC && sh_r[1][4:0] != 5'h00 && sh_r[1][4:0] != 5'h1F;
  ////////////////////
  // register shadow, quiet time, red gap and run length
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) sh_r <= '{default: 8'h00};
    else if (req.wr && hit) sh_r[req.addr[1:0]] <= req.wdata;
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) qt_r <= 16'h0000;
    else qt_r <= req.wr ? 16'h0000 : qt_r + 16'(qt_r != 16'hFFFF);
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) gp_r <= 16'h0000;
    else gp_r <= $rose(led_on.red) ? 16'h0001 : gp_r + 16'(gp_r != 16'hFFFF);
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) rn_r <= 16'h0000;
    else rn_r <= led_on.red ? rn_r + 16'h0001 : 16'h0000;
  end
  ////////////////////
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!nrst);
  en_gate_a: assert property (led_on != '0 |-> $past(sh_r[2][7]) || $past(sh_r[2][7], 2))
    else $error("led on while off");
  iset_copy_a: assert property (sink_current_code == $past(sh_r[1][6:5]))
    else $error("current code");
  read_map_a: assert property (rdata == $past(rx))
    else $error("read data");
  full_on_a: assert property (on && sh_r[1][4:0] == 5'h1F |-> led_on.red)
    else $error("code 31 not on");
  pulse_len_a: assert property (okp && $fell(led_on.red) |-> rn_r == sh_r[1][4:0] * 16'h01CE)
    else $error("pulse length");
  slot_gap_a: assert property (okp && $rose(led_on.red) |-> gp_r == SUB_CYC)
    else $error("slot spacing");
  green_shift_a: assert property (okp && !sh_r[2][6] && $rose(led_on.green) |-> gp_r == 16'h0FA0)
    else $error("green shift");
  blue_shift_a: assert property (okp && sh_r[2][6] && $rose(led_on.blue) |-> gp_r == 16'h0FA0)
    else $error("blue shift");
  cover property (okp && $rose(led_on.green));
  cover property (okp && $rose(led_on.blue));
  cover property (sh_r[0][3:0] != 4'hF && $fell(led_on.red));
endmodule // tlfm_sva
bind tlfm_top tlfm_sva #(.SUB_CYC(SUB_CYC)) tlfm_sva_i (.clock(clock), .nrst(nrst), .req(req),
  .rdata(rdata), .led_on(led_on), .sink_current_code(sink_current_code));

// ===== tb/tlfm_top_test.sv
// bench for the led modulator: registers, gating, phase, flash
// assumes short slot and tick parameters
`timescale 1ns/1ps
module tlfm_top_test;
  import tlfm_pkg::*;
  localparam int unsigned SC = 5000;
  localparam logic [3:0][7:0] PAT = {8'hFF, 8'h5F, 8'h7F, 8'h8F};
  logic clock, nrst, clr;
  tlfm_req_s req;
  logic [7:0] rdata;
  tlfm_rgb_s led_on;
  logic [1:0] sink_current_code;
  logic [4:0][15:0] cnt;
  int error_cnt, total_checks, cyc;
  tlfm_top #(.SUB_CYC(SC), .TICK_CYC(20)) tlfm_top_i (.clock(clock), .nrst(nrst), .req(req),
    .rdata(rdata), .led_on(led_on), .sink_current_code(sink_current_code));
  tlfm_leds tlfm_leds_i (.clock(clock), .clr(clr), .led_on(led_on), .cnt(cnt));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  ////////////////////
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clock);
    req <= '{wr: 1'b1, addr: a, wdata: d};
    @(posedge clock);
    req.wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge clock);
    req.addr <= a;
    repeat (3) @(posedge clock);
    #1 check("rdata", 16'(rdata), 16'(e));
  endtask
  // count sink cycles over a window of n clocks
  task automatic meas(int n, logic [4:0][15:0] e);
    @(posedge clock);
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
    repeat (n) @(posedge clock);
    #1 for (int i = 0; i < 5; i++) check("led count", cnt[i], e[i]);
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 50000) begin
      error_cnt++;
      conclude();
    end
  end
  ////////////////////
  initial begin
    nrst = 1'b0;
    clr = 1'b0;
    req = '0;
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    for (int i = 0; i < 4; i++) rd(8'h50 + 8'(i), 8'h00);
    wr(8'h60, 8'hAA);
    rd(8'h60, 8'h00);
    for (int i = 0; i < 4; i++) wr(8'h50 + 8'(i), PAT[i]);
    for (int i = 0; i < 4; i++) rd(8'h50 + 8'(i), PAT[i]);
    check("current code", 16'(sink_current_code), 16'h0003);
    meas(200, '0);
    wr(8'h52, 8'h9F);
    meas(100, {5{16'h0064}});
    $display("test registers done");
    wr(8'h51, 8'h01);
    wr(8'h52, 8'h82);
    wr(8'h53, 8'h02);
    repeat (2 * SC + 100) @(posedge clock);
    check("current code", 16'(sink_current_code), 16'h0000);
    meas(SC, {16'h01CE, 16'h0000, 16'h039C, 16'h039C, 16'h01CE});
    wr(8'h52, 8'hC2);
    repeat (2 * SC + 100) @(posedge clock);
    meas(SC, {16'h0000, 16'h01CE, 16'h039C, 16'h039C, 16'h01CE});
    $display("test phase done");
    wr(8'h51, 8'h1F);
    wr(8'h52, 8'h80);
    wr(8'h53, 8'h00);
    for (int i = 0; i < 2; i++) begin
      wr(8'h50, i ? 8'h71 : 8'h00);
      repeat (700) @(posedge clock);
      meas(i ? 1200 : 800, {64'h0, (i ? 16'h01E0 : 16'h0050)});
    end
    wr(8'h52, 8'h00);
    wr(8'h52, 8'h80);
    meas(15, {64'h0, 16'h000F});
    $display("test flash done");
    conclude();
  end
endmodule // tlfm_top_test
